// File: core/amvd_top.sv
// Purpose: address classification, nonvolatile loads and vector slots
// Assumes: cpu address and strobes synchronous to ref_clk
// Notes: outputs registered, one cycle after the address
`timescale 1ns/10ps
module amvd_top (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [15:0] cpu_addr,
    input wire logic direct_mode,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic [4:0] vec_slot,
    input wire logic vec_req,
    input wire logic flash_prog,
    input wire logic [3:0] flash_addr,
    input wire logic [7:0] flash_data,
    input wire logic [7:0] wdata,
    input wire logic [7:0] fixed_zero_mask,
    output logic [3:0] sel,
    output logic sel_dp,
    output logic sel_hp,
    output logic sel_nv,
    output logic sel_mem,
    output logic [7:0] nv_rdata,
    output logic [7:0] masked_wdata,
    output logic [7:0] nonvolatile_protection_byte,
    output logic [7:0] nonvolatile_option_byte,
    output logic load_done,
    output logic [15:0] vec_hi_addr,
    output logic [15:0] vec_lo_addr,
    output logic vec_valid
);
    import amvd_pkg::*;
    amvd_nv_if nv ();

    // store keeps its cells through reset, as flash does
    amvd_nv_mem u_mem (
        .ref_clk(ref_clk),
        .nv(nv)
    );

    function automatic logic in_range(
        input logic [15:0] a,
        input logic [15:0] lo,
        input logic [15:0] hi
    );
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // slot index to byte address; high byte even, low byte odd
    function automatic logic [15:0] vec_byte_addr(
        input logic [4:0] slot,
        input logic odd
    );
        vec_byte_addr = VEC_BASE | {10'h000, slot, odd};
    endfunction : vec_byte_addr

    // direct mode drops the upper byte; bit 7 low keeps it inside the register page
    wire [15:0] eff_addr = direct_mode ? {8'h00, 1'b0, cpu_addr[6:0]} : cpu_addr;
    wire hit_dp = in_range(eff_addr, DP_LO, DP_HI);
    wire hit_hp = in_range(eff_addr, HP_LO, HP_HI);
    wire hit_nv = in_range(eff_addr, NV_LO, NV_HI);
    // priority only matters if the ranges are ever moved to overlap
    wire [3:0] sel_w = hit_dp ? AMVD_SEL_DP : hit_hp ? AMVD_SEL_HP :
        hit_nv ? AMVD_SEL_NV : AMVD_SEL_MEM;
    wire bus_act = cpu_rd || cpu_wr;
    wire qsel_dp = sel_w[0] && bus_act;
    wire qsel_hp = sel_w[1] && bus_act;
    wire qsel_nv = sel_w[2] && bus_act;
    wire qsel_mem = sel_w[3] && bus_act;

    wire [15:0] vec_hi_w = vec_byte_addr(vec_slot, 1'b0);
    wire [15:0] vec_lo_w = vec_byte_addr(vec_slot, 1'b1);

    // bits set in fixed_zero_mask are forced to zero in the write data
    wire [7:0] mwd_w = wdata & ~fixed_zero_mask;

    // bus writes never reach the store; only the flash program path does
    wire nv_pwe = flash_prog;

    amvd_ld_t ld_r;
    amvd_ld_t ld_nxt;
    logic ld_wait_r;
    wire ld_in_prot = (ld_r == AMVD_LD_PROT);
    wire ld_in_opt = (ld_r == AMVD_LD_OPT);
    wire ld_in_done = (ld_r == AMVD_LD_DONE);
    wire take_prot = ld_in_prot && ld_wait_r;
    wire take_opt = ld_in_opt && ld_wait_r;
    wire [3:0] ld_addr = ld_in_prot ? NV_PROT_IDX : NV_OPT_IDX;
    wire [3:0] run_addr = flash_prog ? flash_addr : eff_addr[3:0];

    // loader owns the store address until both bytes are in
    assign nv.addr = ld_in_done ? run_addr : ld_addr;
    assign nv.pdata = flash_data;
    // programming during the load is dropped, not queued
    assign nv.pwe = nv_pwe && ld_in_done;

    always_comb begin
        ld_nxt = ld_r;
        unique case (ld_r)
            AMVD_LD_PROT: begin
                if (ld_wait_r) begin
                    ld_nxt = AMVD_LD_OPT;
                end
            end
            AMVD_LD_OPT: begin
                if (ld_wait_r) begin
                    ld_nxt = AMVD_LD_DONE;
                end
            end
            AMVD_LD_DONE: begin
                ld_nxt = AMVD_LD_DONE;
            end
            default: begin
                ld_nxt = AMVD_LD_PROT;
            end
        endcase
    end

    // reload at every reset, read takes two cycles through the store
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ld_r <= AMVD_LD_PROT;
            ld_wait_r <= 1'b0;
        end else begin
            ld_r <= ld_nxt;
            ld_wait_r <= (ld_nxt == ld_r) && !ld_wait_r && !ld_in_done;
        end
    end

    // working copy reads erased until the loader has fetched it
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            nonvolatile_protection_byte <= PROT_RST;
        end else if (take_prot) begin
            nonvolatile_protection_byte <= nv.rdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            nonvolatile_option_byte <= OPT_RST;
        end else if (take_opt) begin
            nonvolatile_option_byte <= nv.rdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            load_done <= 1'b0;
        end else begin
            load_done <= (ld_nxt == AMVD_LD_DONE);
        end
    end

    // region code is unqualified so it shows the decode even when idle
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sel <= AMVD_SEL_MEM;
        end else begin
            sel <= sel_w;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sel_dp <= 1'b0;
        end else begin
            sel_dp <= qsel_dp;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sel_hp <= 1'b0;
        end else begin
            sel_hp <= qsel_hp;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sel_nv <= 1'b0;
        end else begin
            sel_nv <= qsel_nv;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sel_mem <= 1'b0;
        end else begin
            sel_mem <= qsel_mem;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            masked_wdata <= 8'h00;
        end else begin
            masked_wdata <= mwd_w;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            vec_hi_addr <= 16'h0000;
        end else begin
            vec_hi_addr <= vec_hi_w;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            vec_lo_addr <= 16'h0000;
        end else begin
            vec_lo_addr <= vec_lo_w;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            vec_valid <= 1'b0;
        end else begin
            vec_valid <= vec_req;
        end
    end

    // key bytes sit at the bottom of the area, read like any nv byte
    assign nv_rdata = nv.rdata;
endmodule : amvd_top

// File: core/amvd_pkg.sv
// Purpose: constants for the address map and vector decode block
// Assumes: 16-bit cpu address, 8-bit data
// Notes: none
// How it works
// - direct page registers selected for addresses 0x0000 to 0x007f.
// - high page registers selected for addresses 0x1800 to 0x185f.
// - nonvolatile area is sixteen flash bytes from 0xffb0 to 0xffbf.
// - at every reset, protection and option bytes load from flash.
// - nonvolatile area holds an eight byte key for secure access.
// - nonvolatile bytes change only by flash program, not bus writes.
// - direct mode supplies low byte only; upper byte taken as zero. Code also forces bit 7 low, so 0x80-0xff land in 0x00-0x7f.
// - every direct page bit supports single bit read modify write.
// - fixed zero bits always read zero whatever is written.
// - vectors at 0xffc0-0xffff, high byte even address, reset on top.
// - port b pin vector at 0xffd4, port a pin vector at 0xffd6.
package amvd_pkg;
    localparam logic [15:0] DP_LO = 16'h0000;
    localparam logic [15:0] DP_HI = 16'h007f;
    localparam logic [15:0] HP_LO = 16'h1800;
    localparam logic [15:0] HP_HI = 16'h185f;
    localparam logic [15:0] NV_LO = 16'hffb0;
    localparam logic [15:0] NV_HI = 16'hffbf;
    localparam logic [3:0] NV_PROT_IDX = 4'hd;
    localparam logic [3:0] NV_OPT_IDX = 4'hf;
    localparam logic [3:0] NV_KEY_IDX = 4'h0;
    localparam logic [15:0] VEC_BASE = 16'hffc0;
    localparam logic [4:0] VEC_RESET = 5'h1f;
    localparam logic [4:0] VEC_SWI = 5'h1e;
    localparam logic [4:0] VEC_IRQ = 5'h1d;
    localparam logic [4:0] VEC_PORTA = 5'h0b;
    localparam logic [4:0] VEC_PORTB = 5'h0a;
    localparam logic [7:0] PROT_RST = 8'hff;
    localparam logic [7:0] OPT_RST = 8'hff;
    typedef enum logic [3:0] {
        AMVD_SEL_DP = 4'b0001,
        AMVD_SEL_HP = 4'b0010,
        AMVD_SEL_NV = 4'b0100,
        AMVD_SEL_MEM = 4'b1000
    } amvd_sel_t;
    typedef enum logic [2:0] {
        AMVD_LD_PROT = 3'b001,
        AMVD_LD_OPT = 3'b010,
        AMVD_LD_DONE = 3'b100
    } amvd_ld_t;
endpackage : amvd_pkg

// File: core/amvd_nv_if.sv
// Purpose: read and program port into the nonvolatile byte store
// Assumes: single clock
// Notes: none
`timescale 1ns/10ps
interface amvd_nv_if;
    logic [3:0] addr;
    logic [7:0] rdata;
    logic [7:0] pdata;
    logic pwe;
    modport store (input addr, input pdata, input pwe, output rdata);
    modport user (output addr, output pdata, output pwe, input rdata);
endinterface : amvd_nv_if

// File: core/amvd_nv_mem.sv
// Purpose: sixteen byte nonvolatile register store
// Assumes: erased cells read all ones
// Notes: registered read data
`timescale 1ns/10ps
module amvd_nv_mem (
    input wire ref_clk,
    amvd_nv_if.store nv
);
    import amvd_pkg::*;
    // cells start erased; the clocked process stays the only writer
    logic [7:0] cell_r [16] = '{default: 8'hff};
    logic [7:0] rdata_r;
    assign nv.rdata = rdata_r;
    // program can only clear bits, like a flash cell
    always_ff @(posedge ref_clk) begin
        if (nv.pwe) begin
            cell_r[nv.addr] <= cell_r[nv.addr] & nv.pdata;
        end
        rdata_r <= cell_r[nv.addr];
    end
endmodule : amvd_nv_mem

// File: bench/amvd_chk.sv
// Purpose: port checks for amvd_top
// Assumes: sync low reset
// Notes: outputs lag inputs by one cycle
`timescale 1ns/10ps
module amvd_chk (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [15:0] cpu_addr,
    input wire logic direct_mode,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic [4:0] vec_slot,
    input wire logic vec_req,
    input wire logic [3:0] sel,
    input wire logic sel_dp,
    input wire logic sel_mem,
    input wire logic load_done,
    input wire logic [15:0] vec_hi_addr,
    input wire logic vec_valid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire pl = !direct_mode;
    dp_select_a: assert property (pl && cpu_addr <= 16'h007f |=> sel == 4'b0001) else $error("dp");
    direct_page_a: assert property (direct_mode && cpu_rd |=> sel_dp) else $error("direct");
    hp_select_a: assert property (pl && cpu_addr inside {[16'h1800:16'h185f]} |=> sel == 4'b0010) else $error("hp");
    nv_select_a: assert property (pl && cpu_addr inside {[16'hffb0:16'hffbf]} |=> sel == 4'b0100) else $error("nv");
    one_region_a: assert property ($onehot(sel)) else $error("onehot");
    idle_quiet_a: assert property (!cpu_rd && !cpu_wr |=> !sel_dp && !sel_mem) else $error("idle");
    vec_slot_a: assert property (vec_req |=> vec_valid && vec_hi_addr == {10'h3ff, $past(vec_slot), 1'b0}) else $error("vec");
    portb_vec_a: assert property (vec_slot == 5'h0a |=> vec_hi_addr == 16'hffd4) else $error("portb");
    load_bound_a: assert property ($rose(nrst) |-> ##[1:8] load_done) else $error("load");
    cover property (vec_valid);
    cover property (sel_dp);
    cover property (load_done && sel_mem);
endmodule : amvd_chk

// File: bench/amvd_cpu_model.sv
// Purpose: cpu side bus and vector fetch driver
// Assumes: requests launched on rising edges
// Notes: one request per two cycles, simple but slow
`timescale 1ns/10ps
module amvd_cpu_model (
    input wire logic ref_clk,
    output logic [15:0] cpu_addr,
    output logic direct_mode,
    output logic cpu_rd,
    output logic cpu_wr,
    output logic [4:0] vec_slot,
    output logic vec_req
);
    initial {cpu_addr, direct_mode, cpu_rd, cpu_wr, vec_slot, vec_req} = '0;
    // stores only via the bus, never counts on dash bits
    task automatic bus(input logic [15:0] a, input logic dm, rd, wr, input logic [4:0] vs, input logic vq);
        @(posedge ref_clk);
        {cpu_addr, direct_mode, cpu_rd, cpu_wr, vec_slot, vec_req} <= {a, dm, rd, wr, vs, vq};
        @(posedge ref_clk);
        #1;
    endtask : bus
endmodule : amvd_cpu_model

// File: bench/amvd_tb_top.sv
// Purpose: self checking bench for amvd_top
// Assumes: erased store reads 0xff
// Notes: random plus boundary addresses
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module amvd_tb_top;
    logic ref_clk = 0, nrst = 0, flash_prog = 0, direct_mode, cpu_rd, cpu_wr, vec_req, dm, vq;
    logic sel_dp, sel_hp, sel_nv, sel_mem, load_done, vec_valid;
    logic [3:0] flash_addr = 0, sel;
    logic [4:0] vec_slot, vs;
    logic [7:0] flash_data = 0, wdata = 0, fixed_zero_mask = 0, nv_rdata, masked_wdata;
    logic [7:0] nonvolatile_protection_byte, nonvolatile_option_byte;
    logic [15:0] cpu_addr, vec_hi_addr, vec_lo_addr, a, ev;
    logic [31:0] seed = 32'hb61c;
    logic [15:0] corner [12] = '{16'h0, 16'h7f, 16'h80, 16'h17ff, 16'h1800, 16'h185f, 16'h1860, 16'hffaf,
        16'hffb0, 16'hffbf, 16'hffc0, 16'hffff};
    int n_errors = 0, comparisons = 0, cycles = 0;
    always #25 ref_clk = ~ref_clk;
    amvd_cpu_model cpu_u (.ref_clk, .cpu_addr, .direct_mode, .cpu_rd, .cpu_wr, .vec_slot, .vec_req);
    amvd_top dut_u (.ref_clk, .nrst, .cpu_addr, .direct_mode, .cpu_rd, .cpu_wr, .vec_slot, .vec_req, .flash_prog,
        .flash_addr, .flash_data, .wdata, .fixed_zero_mask, .sel, .sel_dp, .sel_hp, .sel_nv, .sel_mem, .nv_rdata,
        .masked_wdata, .nonvolatile_protection_byte, .nonvolatile_option_byte, .load_done, .vec_hi_addr,
        .vec_lo_addr, .vec_valid);
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic [3:0] exp_sel(input logic [15:0] x, input logic d);
        if (d || x <= 16'h7f) return 4'b0001;
        if (x >= 16'h1800 && x <= 16'h185f) return 4'b0010;
        if (x >= 16'hffb0 && x <= 16'hffbf) return 4'b0100;
        return 4'b1000;
    endfunction : exp_sel
    task automatic results();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    task automatic do_reset();
        @(posedge ref_clk);
        nrst <= 0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1;
        for (int i = 0; i < 20 && load_done !== 1'b1; i++) @(posedge ref_clk);
        #1;
        `CHK("load", 1'b1, load_done)
    endtask : do_reset
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 1000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        do_reset();
        `CHK("prot", 8'hff, nonvolatile_protection_byte)
        for (int i = 0; i < 60; i++) begin
            seed = lfsr_next(seed);
            a = i < 12 ? corner[i] : seed[15:0];
            dm = i >= 40 && seed[16];
            vs = 5'(i);
            vq = i < 32;
            ev = 16'hffc0 + 16'(vs) * 16'h2;
            @(posedge ref_clk);
            wdata <= seed[23:16];
            fixed_zero_mask <= seed[31:24];
            cpu_u.bus(a, dm, seed[17], seed[25], vs, vq);
            `CHK("sel", exp_sel(a, dm), sel)
            `CHK("qual", (seed[17] | seed[25]) ? exp_sel(a, dm) : 4'h0, {sel_mem, sel_nv, sel_hp, sel_dp})
            `CHK("mask", seed[23:16] & ~seed[31:24], masked_wdata)
            if (vq) `CHK("vec", {ev, ev | 16'h1}, {vec_hi_addr, vec_lo_addr})
            `CHK("vld", vq, vec_valid)
            if (vs == 5'h0b) `CHK("porta", 16'hffd6, vec_hi_addr)
        end
        wdata <= 8'h00;
        cpu_u.bus(16'hffbd, 1'b0, 1'b0, 1'b1, 5'h0, 1'b0);
        cpu_u.bus(16'hffbd, 1'b0, 1'b1, 1'b0, 5'h0, 1'b0);
        `CHK("nv_wr", 8'hff, nv_rdata)
        @(posedge ref_clk);
        {flash_addr, flash_data, flash_prog} <= {4'hd, 8'h5a, 1'b1};
        @(posedge ref_clk);
        {flash_addr, flash_data} <= {4'h0, 8'h3c};
        @(posedge ref_clk);
        flash_prog <= 0;
        cpu_u.bus(16'hffb0, 1'b0, 1'b1, 1'b0, 5'h0, 1'b0);
        `CHK("key", 8'h3c, nv_rdata)
        do_reset();
        `CHK("prot_ld", 16'h5aff, {nonvolatile_protection_byte, nonvolatile_option_byte})
        results();
    end
endmodule : amvd_tb_top
bind amvd_top amvd_chk chk_u (.ref_clk, .nrst, .cpu_addr, .direct_mode, .cpu_rd, .cpu_wr, .vec_slot, .vec_req,
    .sel, .sel_dp, .sel_mem, .load_done, .vec_hi_addr, .vec_valid);
